// [rtl/tc_pkg.sv]
package tc_pkg;
  localparam int TC_ADDR_W = 8;
  localparam int TC_CNT_W = 16;
  // Register byte offsets
  localparam logic [7:0] TC_OFF_CNT_LO = 8'h00;
  localparam logic [7:0] TC_OFF_CNT_HI = 8'h04;
  localparam logic [7:0] TC_OFF_STATUS = 8'h08;
  localparam logic [7:0] TC_OFF_MASK = 8'h0C;
  localparam logic [7:0] TC_OFF_CTRL = 8'h10;
  // timer_control field positions
  localparam int TC_BIT_RUN = 0;
  localparam int TC_BIT_SRC = 1;
  localparam int TC_BIT_NOSYNC = 2;
  localparam int TC_BIT_LPOSC = 3;
  localparam int TC_PS_LSB = 4;
  localparam int TC_BIT_GATE = 6;
  localparam logic [7:0] TC_CTRL_RESET = 8'h00;
  localparam logic [7:0] TC_CTRL_WMASK = 8'h7F;
  // Status and mask layout
  localparam int TC_BIT_OVF = 0;
  localparam logic [15:0] TC_CNT_RESET = 16'h0000;
  localparam logic [15:0] TC_CNT_MAX = 16'hFFFF;
  // Instruction cycle is four system clocks
  localparam int TC_INSTR_DIV = 4;
  localparam logic [1:0] TC_INSTR_LAST = 2'(TC_INSTR_DIV - 1);
  // Prescale encodings
  typedef enum logic [1:0] {
    TC_PS_DIV1 = 2'b00,
    TC_PS_DIV2 = 2'b01,
    TC_PS_DIV4 = 2'b10,
    TC_PS_DIV8 = 2'b11
  } tc_ps_t;
endpackage

// [rtl/tc_prescale.sv]
`timescale 1ns/10ps
module tc_prescale
  import tc_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic tick_in, // Source tick
  input wire logic clear, // Zero the counter
  input wire tc_ps_t sel, // Divide ratio
  output logic tick_out // Divided tick
);
  logic [2:0] cnt;
  logic [2:0] last;

  always_comb begin
    unique case (sel)
      TC_PS_DIV1: last = 3'h0;
      TC_PS_DIV2: last = 3'h1;
      TC_PS_DIV4: last = 3'h3;
      TC_PS_DIV8: last = 3'h7;
    endcase
  end

  // Counter state is never exposed; only cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
    end else if (clear) begin
      cnt <= 3'h0;
    end else if (tick_in) begin
      cnt <= (cnt >= last) ? 3'h0 : cnt + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && !clear && (cnt >= last);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PS_CLEAR: assert property (clear |=> cnt == 3'h0)
    else $error("prescale counter not cleared by count write");
  AST_PS_DIV8: assert property (
    (sel == TC_PS_DIV8 && tick_in && !clear && cnt == 3'h3) |=> !tick_out)
    else $error("divide by 8 ticked too early");
  AST_PS_DIV1: assert property (
    (sel == TC_PS_DIV1 && tick_in && !clear) |=> tick_out)
    else $error("divide by 1 missed a tick");
endmodule

// [rtl/tc_timer.sv]
`timescale 1ns/10ps
// How it works
// - Prescaler divides the timer clock by 1, 2, 4 or 8 per 2-bit field.
// - Software has no read or write path to the prescale counter.
// - Writing either count byte clears the prescale counter.
// - External mode counts rises only after a fall seen since enabling.
// - Oscillator enable bit acts only under internal oscillator without clock out.
// - External source: sync-disable bit set bypasses synchroniser, clear synchronises.
// - Unsynchronised mode counts edges taken through a single capture flop.
// - Unsynchronised mode counts in sleep; overflow interrupt can wake.
// - Internal source counts once per four clocks; external on rising edges.
// - Count rolls FFFF to 0000 and sets a sticky overflow flag.
module tc_timer
  import tc_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [TC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ext_clock_pin, // External timer clock
  input wire logic lp_osc_in, // Low-power oscillator output
  input wire logic gate_pin_n, // Gate, active low
  input wire logic internal_oscillator_no_clkout, // System on internal osc, no clock out
  input wire logic sleep_in, // Processor asleep
  output logic irq, // Level interrupt
  output logic wake // Wake request during sleep
);
  logic [7:0] ctrl;
  logic [15:0] count;
  logic ovf_flag;
  logic ovf_mask;
  logic run;
  logic src_ext;
  logic nosync;
  logic gate_en;
  logic lp_active;
  logic ext_async;
  logic src_raw;
  logic sync1;
  logic sync2;
  logic async1;
  logic ext_level;
  logic ext_prev;
  logic ext_rise;
  logic ext_fall;
  logic armed;
  logic [1:0] instr_cnt;
  logic instr_tick;
  logic src_tick;
  logic gate_ok;
  logic running;
  logic ps_in;
  logic ps_tick;
  logic acc;
  logic wr;
  logic wr_lo;
  logic wr_hi;
  logic cnt_wr;
  logic ovf_event;
  logic ovf_clr;
  logic mapped;
  logic [31:0] rd_mux;

  assign run = ctrl[TC_BIT_RUN];
  assign src_ext = ctrl[TC_BIT_SRC];
  assign nosync = ctrl[TC_BIT_NOSYNC];
  assign gate_en = ctrl[TC_BIT_GATE];
  assign lp_active = ctrl[TC_BIT_LPOSC] && internal_oscillator_no_clkout;
  assign ext_async = src_ext && nosync;

  // APB access phase completes on the cycle pready is high
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && pstrb[0];
  assign wr_lo = wr && paddr == TC_OFF_CNT_LO;
  assign wr_hi = wr && paddr == TC_OFF_CNT_HI;
  assign cnt_wr = wr_lo || wr_hi;
  assign ovf_clr = wr && paddr == TC_OFF_STATUS && pwdata[TC_BIT_OVF];

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      TC_OFF_CNT_LO: rd_mux[7:0] = count[7:0];
      TC_OFF_CNT_HI: rd_mux[7:0] = count[15:8];
      TC_OFF_STATUS: rd_mux[TC_BIT_OVF] = ovf_flag;
      TC_OFF_MASK: rd_mux[TC_BIT_OVF] = ovf_mask;
      TC_OFF_CTRL: rd_mux[7:0] = ctrl & TC_CTRL_WMASK;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait state: answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= TC_CTRL_RESET;
    end else if (wr && paddr == TC_OFF_CTRL) begin
      ctrl <= pwdata[7:0] & TC_CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_mask <= 1'b0;
    end else if (wr && paddr == TC_OFF_MASK) begin
      ovf_mask <= pwdata[TC_BIT_OVF];
    end
  end

  // Source select: crystal oscillator or pin
  assign src_raw = lp_active ? lp_osc_in : ext_clock_pin;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= src_raw;
      sync2 <= sync1;
    end
  end

  // Single-stage capture for the unsynchronised path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async1 <= 1'b0;
    end else begin
      async1 <= src_raw;
    end
  end

  assign ext_level = nosync ? async1 : sync2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  assign ext_rise = ext_level && !ext_prev;
  assign ext_fall = !ext_level && ext_prev;

  // A rise counts only once a fall has been seen since enabling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (!run) begin
      armed <= 1'b0;
    end else if (ext_fall) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_cnt <= 2'h0;
    end else begin
      instr_cnt <= instr_cnt + 2'h1;
    end
  end

  assign instr_tick = instr_cnt == TC_INSTR_LAST;
  assign src_tick = src_ext ? (ext_rise && armed) : instr_tick;
  assign gate_ok = !gate_en || !gate_pin_n;
  assign running = run && gate_ok && (!sleep_in || ext_async);
  assign ps_in = running && src_tick;

  tc_prescale u_ps (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(ps_in),
    .clear(cnt_wr),
    .sel(tc_ps_t'(ctrl[TC_PS_LSB +: 2])),
    .tick_out(ps_tick)
  );

  assign ovf_event = ps_tick && !cnt_wr && count == TC_CNT_MAX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= TC_CNT_RESET;
    end else if (wr_lo) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr_hi) begin
      count[15:8] <= pwdata[7:0];
    end else if (ps_tick) begin
      count <= count + 16'h0001;
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag <= 1'b0;
    end else if (ovf_event) begin
      ovf_flag <= 1'b1;
    end else if (ovf_clr) begin
      ovf_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq <= ovf_flag && ovf_mask;
      wake <= ovf_flag && ovf_mask && sleep_in && ext_async;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_instr_gap;
    !instr_tick [*3] ##1 instr_tick;
  endsequence

  sequence s_rollover;
    ps_tick && !cnt_wr && count == TC_CNT_MAX;
  endsequence

  AST_ROLL: assert property (s_rollover |=> count == TC_CNT_RESET && ovf_flag)
    else $error("rollover did not clear count and set flag");
  AST_FLAG_HOLD: assert property ((ovf_flag && !ovf_clr) |=> ovf_flag)
    else $error("overflow flag dropped without clear");
  AST_INSTR: assert property (instr_tick |=> s_instr_gap)
    else $error("instruction tick not every four clocks");
  AST_ARM: assert property ((src_ext && !armed) |-> !src_tick)
    else $error("external rise counted before a fall");
  AST_GATE: assert property ((gate_en && gate_pin_n) |-> !ps_in)
    else $error("counted while gate pin high");
  // Two quiet stopped cycles: any tick still in flight has landed by then
  AST_STOP: assert property (
    (!run && !cnt_wr) ##1 (!run && !cnt_wr) |=> $stable(count))
    else $error("count moved while stopped");
  AST_SLEEP: assert property ((sleep_in && !ext_async) |-> !ps_in)
    else $error("counted in sleep outside unsynchronised mode");
  AST_LPOSC: assert property (!internal_oscillator_no_clkout |-> !lp_active)
    else $error("oscillator enable honoured in wrong configuration");
  AST_TOPBIT: assert property (
    (psel && !penable && !pwrite && paddr == TC_OFF_CTRL) |=> prdata[31:7] == 25'h0)
    else $error("top control bit read nonzero");
  AST_IRQ: assert property ((ovf_flag && ovf_mask) |=> irq)
    else $error("interrupt not raised for unmasked flag");
endmodule

// [sim/tc_clk_src.sv]
`timescale 1ns/10ps
module tc_clk_src (
  input wire logic pclk, // System clock
  output logic ext_clock_pin, // Pin clock
  output logic lp_osc_in // Crystal output
);
  initial begin
    ext_clock_pin = 1'b1;
    lp_osc_in = 1'b1;
  end
  // Sources stand still between bursts
  task automatic park(input logic v);
    ext_clock_pin <= v;
    @(posedge pclk);
  endtask
  // 2n toggles, hp clocks per half
  task automatic burst(input bit lp, input int n, input int hp);
    for (int i = 0; i < 2 * n; i++) begin
      if (lp)
        lp_osc_in <= ~lp_osc_in;
      else
        ext_clock_pin <= ~ext_clock_pin;
      repeat (hp) @(posedge pclk);
    end
  endtask
endmodule

// [sim/gated_timer_prescale_control_test.sv]
`timescale 1ns/10ps
module gated_timer_prescale_control_test;
  import tc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, wake;
  logic gate_pin_n, internal_oscillator_no_clkout, sleep_in, ext_clock_pin, lp_osc_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] c;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  tc_clk_src SRC (.pclk(pclk), .ext_clock_pin(ext_clock_pin), .lp_osc_in(lp_osc_in));
  tc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
    .lp_osc_in(lp_osc_in), .gate_pin_n(gate_pin_n), .internal_oscillator_no_clkout(internal_oscillator_no_clkout),
    .sleep_in(sleep_in), .irq(irq), .wake(wake));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches %0d compares %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdcnt();
    apb(1'b0, TC_OFF_CNT_LO, 32'h0000_0000);
    c[7:0] = rd[7:0];
    apb(1'b0, TC_OFF_CNT_HI, 32'h0000_0000);
    c[15:8] = rd[7:0];
  endtask
  task automatic setcnt(input logic [7:0] v);
    apb(1'b1, TC_OFF_CNT_LO, {24'h0000_00, v});
    apb(1'b1, TC_OFF_CNT_HI, {24'h0000_00, v});
  endtask
  // Count is zeroed before the new control value is written
  task automatic run(input logic [7:0] ctl, input bit lp, input int n, input int w);
    setcnt(8'h00);
    apb(1'b1, TC_OFF_CTRL, {24'h0000_00, ctl});
    SRC.burst(lp, n, 4);
    repeat (w) @(posedge pclk);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0000);
    rdcnt();
  endtask
  task automatic t_regs();
    apb(1'b0, TC_OFF_CTRL, 32'h0000_0000);
    chk(rd, {24'h0000_00, TC_CTRL_RESET});
    apb(1'b1, TC_OFF_CTRL, 32'h0000_00FE);
    apb(1'b0, TC_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_007E);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0000);
  endtask
  task automatic t_internal();
    for (int p = 0; p < 4; p++) begin
      run({2'b00, 2'(p), 4'h1}, 1'b0, 0, 32 << p);
      chk_rng(c, 16'h0007, 16'h0009);
    end
    run(8'h40, 1'b0, 0, 16);
    chk({16'h0000, c}, 32'h0000_0000);
    run(8'h41, 1'b0, 0, 64);
    chk({16'h0000, c}, 32'h0000_0000);
    gate_pin_n <= 1'b0;
    run(8'h41, 1'b0, 0, 64);
    chk_rng(c, 16'h000E, 16'h0012);
    gate_pin_n <= 1'b1;
  endtask
  task automatic t_ext();
    for (int s = 0; s < 2; s++) begin
      SRC.park(1'b0);
      run({5'h00, 1'(s), 2'b11}, 1'b0, 3, 8);
      chk({16'h0000, c}, 32'h0000_0002);
    end
    SRC.park(1'b1);
    setcnt(8'h00);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0033);
    SRC.burst(1'b0, 5, 4);
    setcnt(8'h00);
    SRC.burst(1'b0, 7, 4);
    rdcnt();
    chk({16'h0000, c}, 32'h0000_0000);
    SRC.burst(1'b0, 1, 4);
    rdcnt();
    chk({16'h0000, c}, 32'h0000_0001);
    internal_oscillator_no_clkout <= 1'b1;
    run(8'h0B, 1'b1, 2, 8);
    chk({16'h0000, c}, 32'h0000_0002);
    internal_oscillator_no_clkout <= 1'b0;
    run(8'h0B, 1'b1, 2, 8);
    chk({16'h0000, c}, 32'h0000_0000);
  endtask
  task automatic t_ovf();
    apb(1'b1, TC_OFF_MASK, 32'h0000_0001);
    setcnt(8'hFF);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0001);
    repeat (16) @(posedge pclk);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0000);
    rdcnt();
    chk_rng(c, 16'h0001, 16'h0005);
    apb(1'b0, TC_OFF_STATUS, 32'h0000_0000);
    chk({rd[30:0], irq}, 32'h0000_0003);
    apb(1'b1, TC_OFF_MASK, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, TC_OFF_MASK, 32'h0000_0001);
    apb(1'b1, TC_OFF_STATUS, 32'h0000_0001);
    @(posedge pclk);
    apb(1'b0, TC_OFF_STATUS, 32'h0000_0000);
    chk({rd[30:0], irq}, 32'h0000_0000);
    sleep_in <= 1'b1;
    setcnt(8'hFF);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0007);
    SRC.burst(1'b0, 1, 4);
    repeat (6) @(posedge pclk);
    chk({30'h0000_0000, irq, wake}, 32'h0000_0003);
    apb(1'b1, TC_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, TC_OFF_STATUS, 32'h0000_0001);
    sleep_in <= 1'b0;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_in, internal_oscillator_no_clkout} = 5'h00;
    gate_pin_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_internal();
    t_ext();
    t_ovf();
    end_sim();
  end
endmodule
